// File: design/pcr_port_ctrl.sv
/*
  Port PHY control register bank behind a classic Wishbone slave, with
  the basic-control and advertisement views that alias its fields.
  Assumes a 32-bit bus, 10 MHz clk_i and a synchronous reset.
*/
// The Wishbone slave port was chosen for this implementation.
// Operation
// - led_blank drives all four LEDs high
// - bit 14 disables the port transmitter
// - writing bit 13 restarts auto-negotiation
// - bit 10 disables automatic crossover selection
// - bit 9 forces MDI-X when crossover fixed
// - bit 7 enables auto-negotiation, resets one
// - negotiation off: speed, duplex from forced bits
// - bit 6 forces 100BT or 10BT
// - bit 5 forces duplex when off/failed
// - bit 4 advertises pause, resets one
// - bits 3,2 advertise 100BT full/half
// - bits 1,0 advertise 10BT full/half
// - bits 15..5 except reserved 12, 11, 8 alias basic control bits
// - bits 4..0 alias advertisement bits
module pcr_port_ctrl (
  input  wire logic        clk_i,            // system clock, 10 MHz
  input  wire logic        rst_i,            // synchronous reset, high
  input  wire logic        wb_cyc_i,         // bus cycle
  input  wire logic        wb_stb_i,         // strobe
  input  wire logic        wb_we_i,          // write enable
  input  wire logic [11:0] wb_adr_i,         // byte address
  input  wire logic [3:0]  wb_sel_i,         // byte enables
  input  wire logic [31:0] wb_dat_i,         // write data
  output logic      [31:0] wb_dat_o,         // read data
  output logic             wb_ack_o,         // acknowledge
  input  wire logic [3:0]  led_i,            // normal LED drive
  output logic             port_led_out_3_o, // LED pin 3
  output logic             port_led_out_2_o, // LED pin 2
  output logic             port_led_out_1_o, // LED pin 1
  output logic             port_led_out_0_o, // LED pin 0
  output logic             tx_disable_o,     // transmitter off
  output logic             autoneg_restart_o,// one-cycle restart pulse
  output logic             autoneg_en_o,     // negotiation enabled
  output logic             auto_mdix_en_o,   // automatic crossover on
  output logic             force_mdix_o,     // forced MDI-X request
  output logic             adv_pause_o,      // advertise pause
  output logic             adv_100_full_o,   // advertise 100BT full
  output logic             adv_100_half_o,   // advertise 100BT half
  output logic             adv_10_full_o,    // advertise 10BT full
  output logic             adv_10_half_o,    // advertise 10BT half
  input  wire logic        an_done_i,        // negotiation complete
  input  wire logic        an_fail_i,        // negotiation failed
  input  wire logic        an_speed_100_i,   // negotiated speed
  input  wire logic        an_full_i,        // negotiated duplex
  input  wire logic        auto_mdix_i,      // automatic crossover choice
  output logic             link_speed_100_o, // resolved speed
  output logic             link_full_o,      // resolved duplex
  output logic             link_mdix_o       // resolved crossover
);

  ////////////////////////////////////////////////////////////////////
  // view and merge helpers

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                          input logic [3:0] sel);
    logic [15:0] r;
    r = old;
    if (sel[0])
      r[7:0] = wd[7:0];
    if (sel[1])
      r[15:8] = wd[15:8];
    return r;
  endfunction

  function automatic logic [15:0] basic_view(input logic [15:0] pc);
    logic [15:0] b;
    b = '0;
    b[pcr_pkg::BC_LED_BLANK]  = pc[pcr_pkg::PC_LED_BLANK];
    b[pcr_pkg::BC_TX_DIS]     = pc[pcr_pkg::PC_TX_DIS];
    b[pcr_pkg::BC_AN_RESTART] = pc[pcr_pkg::PC_AN_RESTART];
    b[pcr_pkg::BC_MDIX_DIS]   = pc[pcr_pkg::PC_MDIX_DIS];
    b[pcr_pkg::BC_FORCE_MDIX] = pc[pcr_pkg::PC_FORCE_MDIX];
    b[pcr_pkg::BC_AN_EN]      = pc[pcr_pkg::PC_AN_EN];
    b[pcr_pkg::BC_FORCE_100]  = pc[pcr_pkg::PC_FORCE_100];
    b[pcr_pkg::BC_FORCE_FULL] = pc[pcr_pkg::PC_FORCE_FULL];
    return b;
  endfunction

  function automatic logic [15:0] basic_apply(input logic [15:0] pc, input logic [15:0] b);
    logic [15:0] r;
    r = pc;
    r[pcr_pkg::PC_LED_BLANK]  = b[pcr_pkg::BC_LED_BLANK];
    r[pcr_pkg::PC_TX_DIS]     = b[pcr_pkg::BC_TX_DIS];
    r[pcr_pkg::PC_AN_RESTART] = b[pcr_pkg::BC_AN_RESTART];
    r[pcr_pkg::PC_MDIX_DIS]   = b[pcr_pkg::BC_MDIX_DIS];
    r[pcr_pkg::PC_FORCE_MDIX] = b[pcr_pkg::BC_FORCE_MDIX];
    r[pcr_pkg::PC_AN_EN]      = b[pcr_pkg::BC_AN_EN];
    r[pcr_pkg::PC_FORCE_100]  = b[pcr_pkg::BC_FORCE_100];
    r[pcr_pkg::PC_FORCE_FULL] = b[pcr_pkg::BC_FORCE_FULL];
    return r;
  endfunction

  function automatic logic [15:0] advert_view(input logic [15:0] pc);
    logic [15:0] a;
    a = '0;
    a[pcr_pkg::AR_PAUSE] = pc[pcr_pkg::PC_ADV_PAUSE];
    a[pcr_pkg::AR_100FD] = pc[pcr_pkg::PC_ADV_100FD];
    a[pcr_pkg::AR_100HD] = pc[pcr_pkg::PC_ADV_100HD];
    a[pcr_pkg::AR_10FD]  = pc[pcr_pkg::PC_ADV_10FD];
    a[pcr_pkg::AR_10HD]  = pc[pcr_pkg::PC_ADV_10HD];
    return a;
  endfunction

  function automatic logic [15:0] advert_apply(input logic [15:0] pc, input logic [15:0] a);
    logic [15:0] r;
    r = pc;
    r[pcr_pkg::PC_ADV_PAUSE] = a[pcr_pkg::AR_PAUSE];
    r[pcr_pkg::PC_ADV_100FD] = a[pcr_pkg::AR_100FD];
    r[pcr_pkg::PC_ADV_100HD] = a[pcr_pkg::AR_100HD];
    r[pcr_pkg::PC_ADV_10FD]  = a[pcr_pkg::AR_10FD];
    r[pcr_pkg::PC_ADV_10HD]  = a[pcr_pkg::AR_10HD];
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////
  // bus front and link resolution

  logic       req;
  logic       commit;
  logic [9:0] idx;
  logic       wr;
  logic       hit_pc;
  logic       hit_bc;
  logic       hit_ar;
  logic       hit_st;
  logic [15:0] status;

  pcr_wb_front u_front (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .cyc_i    (wb_cyc_i),
    .stb_i    (wb_stb_i),
    .ack_o    (wb_ack_o),
    .req_o    (req),
    .commit_o (commit)
  );

  pcr_pkg::pcr_main_t s;
  pcr_pkg::pcr_main_t next_s;

  pcr_link_resolve u_link (
    .clk_i          (clk_i),
    .rst_i          (rst_i),
    .an_en_i        (s.pc[pcr_pkg::PC_AN_EN]),
    .force_100_i    (s.pc[pcr_pkg::PC_FORCE_100]),
    .force_full_i   (s.pc[pcr_pkg::PC_FORCE_FULL]),
    .mdix_dis_i     (s.pc[pcr_pkg::PC_MDIX_DIS]),
    .force_mdix_i   (s.pc[pcr_pkg::PC_FORCE_MDIX]),
    .an_done_i      (an_done_i),
    .an_fail_i      (an_fail_i),
    .an_speed_100_i (an_speed_100_i),
    .an_full_i      (an_full_i),
    .auto_mdix_i    (auto_mdix_i),
    .speed_100_o    (link_speed_100_o),
    .full_o         (link_full_o),
    .mdix_o         (link_mdix_o)
  );

  assign idx    = wb_adr_i[11:2];
  assign wr     = commit & wb_we_i;
  assign hit_pc = (idx == pcr_pkg::IDX_PORT_CTRL);
  assign hit_bc = (idx == pcr_pkg::IDX_BASIC_CTRL);
  assign hit_ar = (idx == pcr_pkg::IDX_ADVERT);
  assign hit_st = (idx == pcr_pkg::IDX_STATUS);

  always_comb
  begin
    status = '0;
    status[pcr_pkg::ST_SPEED_100] = link_speed_100_o;
    status[pcr_pkg::ST_FULL]      = link_full_o;
    status[pcr_pkg::ST_MDIX]      = link_mdix_o;
    status[pcr_pkg::ST_AN_DONE]   = an_done_i;
    status[pcr_pkg::ST_AN_FAIL]   = an_fail_i;
  end

  ////////////////////////////////////////////////////////////////////
  // register state

  always_comb
  begin
    next_s = s;
    // restart holds for one cycle only; a write in that cycle sets it again
    next_s.pc[pcr_pkg::PC_AN_RESTART] = 1'b0;
    // writes land at the ack edge; reserved bits 12, 11, 8 simply store
    if (wr && hit_pc)
      next_s.pc = merge16(s.pc, wb_dat_i, wb_sel_i);
    else if (wr && hit_bc)
      next_s.pc = basic_apply(next_s.pc, merge16(basic_view(s.pc), wb_dat_i, wb_sel_i));
    else if (wr && hit_ar)
      next_s.pc = advert_apply(next_s.pc, merge16(advert_view(s.pc), wb_dat_i, wb_sel_i));
    // read data is captured on the first request cycle; unmapped reads zero
    if (req)
    begin
      if (hit_pc)
        next_s.dat = {16'h0000, s.pc};
      else if (hit_bc)
        next_s.dat = {16'h0000, basic_view(s.pc)};
      else if (hit_ar)
        next_s.dat = {16'h0000, advert_view(s.pc)};
      else if (hit_st)
        next_s.dat = {16'h0000, status};
      else
        next_s.dat = '0;
    end
    next_s.led = s.pc[pcr_pkg::PC_LED_BLANK] ? pcr_pkg::LED_ALL_OFF : led_i;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s.pc  <= pcr_pkg::PC_RESET;
      s.dat <= '0;
      s.led <= pcr_pkg::LED_ALL_OFF;
    end
    else
      s <= next_s;
  end

  ////////////////////////////////////////////////////////////////////
  // outputs

  assign wb_dat_o          = s.dat;
  assign port_led_out_3_o  = s.led[3];
  assign port_led_out_2_o  = s.led[2];
  assign port_led_out_1_o  = s.led[1];
  assign port_led_out_0_o  = s.led[0];
  assign tx_disable_o      = s.pc[pcr_pkg::PC_TX_DIS];
  assign autoneg_restart_o = s.pc[pcr_pkg::PC_AN_RESTART];
  assign autoneg_en_o      = s.pc[pcr_pkg::PC_AN_EN];
  assign auto_mdix_en_o    = ~s.pc[pcr_pkg::PC_MDIX_DIS];
  assign force_mdix_o      = s.pc[pcr_pkg::PC_FORCE_MDIX];
  assign adv_pause_o       = s.pc[pcr_pkg::PC_ADV_PAUSE];
  assign adv_100_full_o    = s.pc[pcr_pkg::PC_ADV_100FD];
  assign adv_100_half_o    = s.pc[pcr_pkg::PC_ADV_100HD];
  assign adv_10_full_o     = s.pc[pcr_pkg::PC_ADV_10FD];
  assign adv_10_half_o     = s.pc[pcr_pkg::PC_ADV_10HD];

  ////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  logic wr_pc_hi;
  logic wr_pc_lo;
  assign wr_pc_hi = wr && hit_pc && wb_sel_i[1];
  assign wr_pc_lo = wr && hit_pc && wb_sel_i[0];

  a_led_blank_on: assert property (
    s.pc[pcr_pkg::PC_LED_BLANK] |=> {port_led_out_3_o, port_led_out_2_o,
      port_led_out_1_o, port_led_out_0_o} == 4'hf)
    else $error("leds not blanked");

  a_led_follow: assert property (
    !s.pc[pcr_pkg::PC_LED_BLANK] |=> {port_led_out_3_o, port_led_out_2_o,
      port_led_out_1_o, port_led_out_0_o} == $past(led_i))
    else $error("leds do not follow normal drive");

  a_tx_disable_wr: assert property (
    wr_pc_hi |=> tx_disable_o == $past(wb_dat_i[14]))
    else $error("transmitter disable not taken from write");

  a_restart_pulse: assert property (
    wr_pc_hi && wb_dat_i[13] |=> autoneg_restart_o ##1 !autoneg_restart_o)
    else $error("restart not a single pulse");

  a_mdix_auto_wr: assert property (
    wr_pc_hi |=> auto_mdix_en_o == !$past(wb_dat_i[10]))
    else $error("auto crossover control wrong");

  a_force_mdix: assert property (
    !auto_mdix_en_o |=> link_mdix_o == $past(force_mdix_o))
    else $error("forced crossover not applied");

  a_reset_values: assert property (
    $fell(rst_i) |-> autoneg_en_o && s.pc == 16'h00ff)
    else $error("control register reset value wrong");

  a_neg_speed: assert property (
    autoneg_en_o && an_done_i |=> link_speed_100_o == $past(an_speed_100_i))
    else $error("negotiated speed not used");

  a_forced_speed: assert property (
    !autoneg_en_o |=> link_speed_100_o == $past(s.pc[pcr_pkg::PC_FORCE_100]))
    else $error("forced speed not applied");

  a_forced_duplex: assert property (
    !autoneg_en_o || an_fail_i |=> link_full_o == $past(s.pc[pcr_pkg::PC_FORCE_FULL]))
    else $error("forced duplex not applied");

  a_advert_wr: assert property (
    wr_pc_lo |=> {adv_pause_o, adv_100_full_o, adv_100_half_o, adv_10_full_o,
      adv_10_half_o} == $past(wb_dat_i[4:0]))
    else $error("advertisement bits not written");

  a_basic_alias: assert property (
    wr && hit_bc && wb_sel_i[1] |=> autoneg_en_o == $past(wb_dat_i[12])
      && s.pc[pcr_pkg::PC_FORCE_100] == $past(wb_dat_i[13]))
    else $error("basic control alias broken");

  a_advert_alias: assert property (
    wr && hit_ar && wb_sel_i[1] |=> adv_pause_o == $past(wb_dat_i[10])
      && adv_100_full_o == $past(wb_dat_i[8]))
    else $error("advertisement alias broken");

  a_reserved_keep: assert property (
    wr_pc_hi |=> s.pc[12:11] == $past(wb_dat_i[12:11]))
    else $error("reserved bits not stored");

  a_ack_single: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");

  a_ack_next: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not acknowledged in the next cycle");

  a_bc_restart: assert property (
    wr && hit_bc && wb_sel_i[1] && wb_dat_i[9] |=> autoneg_restart_o)
    else $error("restart not reached through basic control");

  a_bc_led_tx: assert property (
    wr && hit_bc && wb_sel_i[0] |=> s.pc[pcr_pkg::PC_LED_BLANK] == $past(wb_dat_i[0])
      && tx_disable_o == $past(wb_dat_i[1]))
    else $error("basic control low byte alias broken");

  a_read_data: assert property (
    wb_ack_o && !wb_we_i && hit_pc |-> wb_dat_o == {16'h0000, $past(s.pc)})
    else $error("port control read data wrong");

  c_restart: cover property (autoneg_restart_o);
  c_forced_link: cover property (!autoneg_en_o ##1 link_speed_100_o);
  c_basic_write: cover property (wr && hit_bc);
  c_led_blank: cover property (port_led_out_0_o && s.pc[pcr_pkg::PC_LED_BLANK]);
  c_neg_fail: cover property (an_fail_i && autoneg_en_o);

endmodule

// File: inc/pcr_pkg.sv
/*
  Shared constants for the port PHY control register block: register
  indices, field positions, reset values and the state structs.
  Assumes a 32-bit classic Wishbone bus with byte addresses.
*/
package pcr_pkg;

  localparam int ADR_W = 12;
  localparam int DAT_W = 32;

  // printed offsets are register indices; the byte address is four times the index
  localparam logic [9:0] IDX_PORT_CTRL  = 10'h0f6;
  localparam logic [9:0] IDX_BASIC_CTRL = 10'h0e4;
  localparam logic [9:0] IDX_ADVERT     = 10'h0ec;
  localparam logic [9:0] IDX_STATUS     = 10'h0fa;

  // port control fields
  localparam int PC_LED_BLANK  = 15;
  localparam int PC_TX_DIS     = 14;
  localparam int PC_AN_RESTART = 13;
  localparam int PC_MDIX_DIS   = 10;
  localparam int PC_FORCE_MDIX = 9;
  localparam int PC_AN_EN      = 7;
  localparam int PC_FORCE_100  = 6;
  localparam int PC_FORCE_FULL = 5;
  localparam int PC_ADV_PAUSE  = 4;
  localparam int PC_ADV_100FD  = 3;
  localparam int PC_ADV_100HD  = 2;
  localparam int PC_ADV_10FD   = 1;
  localparam int PC_ADV_10HD   = 0;

  localparam logic [15:0] PC_RESET = 16'h00ff;

  // alias positions in the basic control view
  localparam int BC_LED_BLANK  = 0;
  localparam int BC_TX_DIS     = 1;
  localparam int BC_MDIX_DIS   = 3;
  localparam int BC_FORCE_MDIX = 4;
  localparam int BC_FORCE_FULL = 8;
  localparam int BC_AN_RESTART = 9;
  localparam int BC_AN_EN      = 12;
  localparam int BC_FORCE_100  = 13;

  // alias positions in the advertisement view
  localparam int AR_PAUSE = 10;
  localparam int AR_100FD = 8;
  localparam int AR_100HD = 7;
  localparam int AR_10FD  = 6;
  localparam int AR_10HD  = 5;

  // status register fields
  localparam int ST_SPEED_100 = 0;
  localparam int ST_FULL      = 1;
  localparam int ST_MDIX      = 2;
  localparam int ST_AN_DONE   = 3;
  localparam int ST_AN_FAIL   = 4;

  localparam logic [3:0] LED_ALL_OFF = 4'hf;

  typedef struct packed {
    logic [15:0] pc;
    logic [31:0] dat;
    logic [3:0]  led;
  } pcr_main_t;

  typedef struct packed {
    logic ack;
  } pcr_front_t;

  typedef struct packed {
    logic speed_100;
    logic full;
    logic mdix;
  } pcr_link_t;

endpackage

// File: design/pcr_wb_front.sv
/*
  Classic Wishbone slave handshake: one registered ack per request.
  Assumes the master holds its request until it samples ack high.
*/
module pcr_wb_front (
  input  wire logic       clk_i,    // system clock
  input  wire logic       rst_i,    // synchronous reset
  input  wire logic       cyc_i,    // bus cycle
  input  wire logic       stb_i,    // strobe
  output logic            ack_o,    // acknowledge
  output logic            req_o,    // new request, first cycle
  output logic            commit_o  // edge at which the access completes
);

  pcr_pkg::pcr_front_t s;
  pcr_pkg::pcr_front_t next_s;

  always_comb
  begin
    next_s     = s;
    // ack falls right after it was seen, so a held request is answered once
    next_s.ack = cyc_i & stb_i & ~s.ack;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      s <= '0;
    else
      s <= next_s;
  end

  assign ack_o    = s.ack;
  assign req_o    = cyc_i & stb_i & ~s.ack;
  assign commit_o = cyc_i & stb_i & s.ack;

endmodule

// File: design/pcr_link_resolve.sv
/*
  Resolves the operating speed, duplex and crossover from the control
  fields and the PHY's negotiation results. Assumes PHY inputs are
  synchronous to clk_i.
*/
module pcr_link_resolve (
  input  wire logic clk_i,          // system clock
  input  wire logic rst_i,          // synchronous reset
  input  wire logic an_en_i,        // auto-negotiation enabled
  input  wire logic force_100_i,    // forced speed
  input  wire logic force_full_i,   // forced duplex
  input  wire logic mdix_dis_i,     // auto crossover disabled
  input  wire logic force_mdix_i,   // forced MDI-X
  input  wire logic an_done_i,      // negotiation complete
  input  wire logic an_fail_i,      // negotiation failed
  input  wire logic an_speed_100_i, // negotiated speed
  input  wire logic an_full_i,      // negotiated duplex
  input  wire logic auto_mdix_i,    // automatic crossover choice
  output logic      speed_100_o,    // resolved speed, 1 = 100BT
  output logic      full_o,         // resolved duplex, 1 = full
  output logic      mdix_o          // resolved crossover, 1 = MDI-X
);

  pcr_pkg::pcr_link_t s;
  pcr_pkg::pcr_link_t next_s;

  always_comb
  begin
    next_s = s;
    if (!an_en_i)
      next_s.speed_100 = force_100_i;
    else if (an_done_i || an_fail_i)
      next_s.speed_100 = an_speed_100_i;
    if (!an_en_i || an_fail_i)
      next_s.full = force_full_i;
    else if (an_done_i)
      next_s.full = an_full_i;
    next_s.mdix = mdix_dis_i ? force_mdix_i : auto_mdix_i;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      s <= '0;
    else
      s <= next_s;
  end

  assign speed_100_o = s.speed_100;
  assign full_o      = s.full;
  assign mdix_o      = s.mdix;

endmodule

// File: testbench/pcr_phy_model.sv
/*
  Behavioural negotiation partner standing behind the PHY pins.
  Assumes restart_i is a one-cycle pulse synchronous to clk_i.
*/
module pcr_phy_model #(
  parameter int NEG_CYCLES = 20
) (
  input  wire logic clk_i,          // system clock
  input  wire logic rst_i,          // synchronous reset
  input  wire logic restart_i,      // restart negotiation pulse
  input  wire logic adv_100_full_i, // advertised 100 full
  input  wire logic adv_100_half_i, // advertised 100 half
  input  wire logic adv_10_full_i,  // advertised 10 full
  input  wire logic fail_i,         // bench commands a failed attempt
  output logic      an_done_o,      // negotiation complete
  output logic      an_fail_o,      // negotiation failed
  output logic      an_speed_100_o, // negotiated speed
  output logic      an_full_o       // negotiated duplex
);
  timeunit 1ns;
  timeprecision 100ps;

  int cnt;
  logic fast;

  assign fast = adv_100_full_i || adv_100_half_i;

  always @(posedge clk_i)
  begin
    if (rst_i || restart_i)
    begin
      cnt <= restart_i ? NEG_CYCLES : 0;
      an_done_o <= 1'b0;
      an_fail_o <= 1'b0;
      an_speed_100_o <= 1'b0;
      an_full_o <= 1'b0;
    end
    else if (cnt == 1)
    begin
      cnt <= 0;
      an_done_o <= !fail_i;
      an_fail_o <= fail_i;
      // a failed attempt reports no speed, so a stale value cannot pass
      an_speed_100_o <= !fail_i && fast;
      an_full_o <= !fail_i && (fast ? adv_100_full_i : adv_10_full_i);
    end
    else if (cnt > 1)
      cnt <= cnt - 1;
  end
endmodule

// File: testbench/pcr_port_ctrl_bench.sv
/*
  Self-checking bench for the port control register bank.
  Assumes the Wishbone acks one cycle after each request.
*/
module pcr_port_ctrl_bench;
  timeunit 1ns;
  timeprecision 100ps;

  localparam logic [11:0] A_PC = {pcr_pkg::IDX_PORT_CTRL, 2'b00};
  localparam logic [11:0] A_BC = {pcr_pkg::IDX_BASIC_CTRL, 2'b00};
  localparam logic [11:0] A_AR = {pcr_pkg::IDX_ADVERT, 2'b00};
  localparam logic [11:0] A_ST = {pcr_pkg::IDX_STATUS, 2'b00};
  localparam logic [11:0] A_UN = 12'h004;

  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [11:0] wb_adr_i = 12'h000;
  logic [3:0] wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic [3:0] led_i = 4'h0;
  logic [3:0] led;
  logic tx_dis, rst_an, an_en, mdix_en, f_mdix;
  logic [4:0] adv;
  logic an_done, an_fail, an_spd, an_full, fail_cmd = 1'b0, mdix_pick = 1'b0;
  logic l_spd, l_full, l_mdix;
  int fail_count = 0;
  int checks = 0;
  int seed = 84;

  always #50 clk_i = ~clk_i;

  pcr_port_ctrl uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .led_i(led_i), .port_led_out_3_o(led[3]),
    .port_led_out_2_o(led[2]), .port_led_out_1_o(led[1]), .port_led_out_0_o(led[0]),
    .tx_disable_o(tx_dis), .autoneg_restart_o(rst_an), .autoneg_en_o(an_en),
    .auto_mdix_en_o(mdix_en), .force_mdix_o(f_mdix), .adv_pause_o(adv[4]),
    .adv_100_full_o(adv[3]), .adv_100_half_o(adv[2]), .adv_10_full_o(adv[1]),
    .adv_10_half_o(adv[0]), .an_done_i(an_done), .an_fail_i(an_fail),
    .an_speed_100_i(an_spd), .an_full_i(an_full), .auto_mdix_i(mdix_pick),
    .link_speed_100_o(l_spd), .link_full_o(l_full), .link_mdix_o(l_mdix));

  pcr_phy_model #(.NEG_CYCLES(20)) phy (.clk_i(clk_i), .rst_i(rst_i), .restart_i(rst_an),
    .adv_100_full_i(adv[3]), .adv_100_half_i(adv[2]), .adv_10_full_i(adv[1]),
    .fail_i(fail_cmd), .an_done_o(an_done), .an_fail_o(an_fail),
    .an_speed_100_o(an_spd), .an_full_o(an_full));

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // one idle cycle precedes every request, so cyc never toggles twice in a step
  task automatic wb(input logic we, input logic [11:0] adr, input logic [31:0] dat,
                    output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= 4'hf;
    wb_dat_i <= dat;
    // no limit here: only the watchdog ends a hung wait
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    chk("ack_lat", 32'(n), 32'd2);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask

  task automatic rd_chk(input string nm, input logic [11:0] adr, input logic [31:0] exp);
    logic [31:0] d;
    wb(1'b0, adr, 32'h0, d);
    chk(nm, d, exp);
  endtask

  function automatic logic [31:0] bc_of(input logic [15:0] v);
    bc_of = 32'h0;
    bc_of[pcr_pkg::BC_LED_BLANK] = v[15];
    bc_of[pcr_pkg::BC_TX_DIS] = v[14];
    bc_of[pcr_pkg::BC_MDIX_DIS] = v[10];
    bc_of[pcr_pkg::BC_FORCE_MDIX] = v[9];
    bc_of[pcr_pkg::BC_AN_EN] = v[7];
    bc_of[pcr_pkg::BC_FORCE_100] = v[6];
    bc_of[pcr_pkg::BC_FORCE_FULL] = v[5];
  endfunction

  function automatic logic [31:0] ar_of(input logic [15:0] v);
    ar_of = 32'h0;
    {ar_of[10], ar_of[8], ar_of[7], ar_of[6], ar_of[5]} = v[4:0];
  endfunction

  task automatic chk_outs(input logic [15:0] v);
    chk("led", led, v[15] ? 4'hf : led_i);
    chk("txdis", tx_dis, v[14]);
    chk("mdixen", mdix_en, !v[10]);
    chk("fmdix", f_mdix, v[9]);
    chk("anen", an_en, v[7]);
    chk("adv", adv, v[4:0]);
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (20000) @(posedge clk_i);
    fail_count++;
    finish_test;
  end

  initial
  begin
    logic [15:0] v, cur;
    logic [31:0] w, d;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd_chk("pc_rst", A_PC, 32'h0000_00ff);
    chk_outs(16'h00ff);
    $display("test reset done");
    for (int i = 0; i < 14; i++)
    begin
      v = (i == 0) ? 16'hffff : (i == 1) ? 16'h0000 : 16'($random(seed));
      led_i <= 4'($random(seed));
      mdix_pick <= 1'($random(seed));
      wb(1'b1, A_PC, {16'h0000, v}, d);
      #1 chk("restart", rst_an, v[13]);
      @(posedge clk_i);
      // the led outputs follow the register one edge later
      #1 chk("restart_clr", rst_an, 1'b0);
      chk_outs(v);
      rd_chk("pc", A_PC, {16'h0000, v & 16'hdfff});
      rd_chk("bc", A_BC, bc_of(v));
      rd_chk("ar", A_AR, ar_of(v));
      chk("lmdix", l_mdix, v[10] ? v[9] : mdix_pick);
      if (!v[7])
      begin
        chk("lspd", l_spd, v[6]);
        chk("lfull", l_full, v[5]);
      end
    end
    $display("test random control done");
    cur = 16'h0000;
    wb(1'b1, A_PC, 32'h0, d);
    for (int i = 0; i < 4; i++)
    begin
      w = 32'($random(seed)) & 32'hffff_fdff;
      wb(1'b1, A_BC, w, d);
      {cur[15], cur[14], cur[10], cur[9]} = {w[0], w[1], w[3], w[4]};
      {cur[7], cur[6], cur[5]} = {w[12], w[13], w[8]};
      rd_chk("pc_bc", A_PC, {16'h0000, cur});
      w = 32'($random(seed));
      wb(1'b1, A_AR, w, d);
      cur[4:0] = {w[10], w[8], w[7], w[6], w[5]};
      rd_chk("pc_ar", A_PC, {16'h0000, cur});
      chk_outs(cur);
    end
    $display("test alias views done");
    fail_cmd <= 1'b1;
    for (int ff = 1; ff >= 0; ff--)
    begin
      v = 16'h209f | 16'(ff << 5);
      wb(1'b1, A_PC, {16'h0000, v}, d);
      // flags of the previous attempt stand until the restart reaches the partner
      repeat (2) @(posedge clk_i);
      for (int n = 0; n < 60 && an_fail !== 1'b1; n++)
        @(posedge clk_i);
      repeat (2) @(posedge clk_i);
      #1 chk("lfull_fail", l_full, v[5]);
    end
    fail_cmd <= 1'b0;
    wb(1'b1, A_PC, 32'h0000_20e5, d);
    for (int n = 0; n < 60 && an_done !== 1'b1; n++)
      @(posedge clk_i);
    repeat (2) @(posedge clk_i);
    #1 chk("lspd_an", l_spd, 1'b1);
    chk("lfull_an", l_full, 1'b0);
    rd_chk("status", A_ST, {27'h0000000, 2'b01, mdix_pick, 2'b01});
    $display("test negotiation done");
    wb(1'b1, A_UN, 32'h0000_ffff, d);
    rd_chk("unmapped", A_UN, 32'h0);
    rd_chk("pc_keep", A_PC, 32'h0000_00e5);
    $display("test unmapped done");
    finish_test;
  end
endmodule
